/* File: testbench/cmor_regs_chk.sv */
`timescale 1ns/1ns
// ****************************************
// Port checker
// ****************************************
module cmor_regs_chk (
    input logic clk,
    input logic resetn,
    input logic spiCsN,
    input logic spiSdo,
    input logic spiSdoOe,
    input logic pllEnable,
    input logic dllEnable,
    input logic refPowerEn,
    input logic clockPowerEn,
    input logic analogPowerEn,
    input logic clockDistEn,
    input logic calRegsInit,
    input logic calStart,
    input logic pllCalStart,
    input logic dllResetPulse,
    input logic dataOutValid,
    input logic outputClockPinsP,
    input logic outputClockPinsN,
    input logic outClkFullRate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_shutdown_all_off: assert property (!refPowerEn |-> !clockPowerEn && !analogPowerEn && !clockDistEn)
        else $error("rails powered while reference is off");
    // Restart held during shutdown keeps the reference off, so only the powered case is checked
    a_restart_keeps_ref: assert property (calRegsInit && analogPowerEn |-> refPowerEn && clockPowerEn && !clockDistEn)
        else $error("wrong power state during restart");
    a_standby_keeps_clock: assert property (!analogPowerEn && refPowerEn |-> clockPowerEn)
        else $error("clocking lost in standby");
    a_output_only_active: assert property (dataOutValid |-> analogPowerEn && clockDistEn)
        else $error("output word outside active state");
    a_cal_single_pulse: assert property (calStart |=> !calStart)
        else $error("calibration start longer than one cycle");
    a_cal_companions: assert property (calStart |-> pllCalStart == pllEnable && dllResetPulse == dllEnable)
        else $error("synth calibration or delay-line reset not paired with calibration start");
    // Leaving restart into shutdown keeps distribution off, so it is not a release
    a_release_calibrates: assert property ($fell(calRegsInit) && clockDistEn |->
        calStart || $past(calStart) || $past(calStart, 2))
        else $error("restart released without calibration");
    a_clock_pins_diff: assert property (outputClockPinsP != outputClockPinsN)
        else $error("clock pin pair not complementary");
    a_full_rate_holds: assert property (outClkFullRate && $past(outClkFullRate) |-> $stable(outputClockPinsP))
        else $error("divided clock toggles in full-rate mode");
    a_sdo_quiet_idle: assert property (spiCsN [*8] |-> !spiSdoOe && !spiSdo)
        else $error("serial output driven while deselected");
endmodule // cmor_regs_chk

/* File: testbench/cmor_spi_host.sv */
`timescale 1ns/1ns
// ****************************************
// Serial host model
// ****************************************
module cmor_spi_host
    import cmor_pkg::*;
#(
    parameter int HALF = 9 // Clocks per serial phase; five above the minimum of 4 that the synchronisers and filter allow
) (
    input  logic clk,
    output logic sclk,
    output logic csN,
    output logic sdi,
    input  logic sdo
);
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        sdi  = 1'b0;
    end

    task automatic xfer(input logic rdOp, input logic [8:0] a, input logic [7:0] wd, input logic lsb,
                        output logic [7:0] q);
        logic [15:0] hdr;
        logic [7:0]  d;
        d   = (!rdOp && a == INDEP_ADDR) ? {wd[7], 7'h0F} : wd;
        hdr = {rdOp, 6'h00, a};
        q   = 8'h00;
        if (!rdOp && a == RATE_ADDR && wd[7:4] inside {[4'hA:4'hC]}) return;
        @(posedge clk);
        #1 csN = 1'b0;
        for (int i = 0; i < 24; i++) begin
            sdi = (i < 16) ? hdr[lsb ? i : 15 - i] : d[lsb ? i - 16 : 23 - i];
            repeat (HALF) @(posedge clk);
            #1 sclk = 1'b1;
            if (i >= 16) q[lsb ? i - 16 : 23 - i] = sdo;
            repeat (HALF) @(posedge clk);
            #1 sclk = 1'b0;
        end
        repeat (HALF) @(posedge clk);
        #1 csN = 1'b1;
        sdi = ~sdi; // Released line must not look like a held bit
        repeat (HALF) @(posedge clk);
        #1; // Callers drive and compare off the sampling edge
    endtask
endmodule // cmor_spi_host

/* File: testbench/tb_cmor_regs.sv */
`timescale 1ns/1ns
// ****************************************
// Bench top
// ****************************************
module tb_cmor_regs
    import cmor_pkg::*;
;
    localparam logic [15:0] ID = 16'hC3A5; // Arbitrary value
    logic        clk, resetn, sclk, csN, sdi, sdo, sdoOe, pllEn, dllEn, adcCal, pllCal, lowDrift, highDrift;
    logic        refEn, clkEn, anaEn, distEn, calInit, calSt, pllSt, dllRst, valid, pinP, pinN, fullRate, lsbMode;
    logic [13:0] adc, dout;
    int          bad_count = 0;
    int          n_compared = 0;
    int          calSeen = 0;

    cmor_regs #(.DEVICE_ID(ID)) i_cmor_regs (
        .clk(clk), .resetn(resetn), .spiSclk(sclk), .spiCsN(csN), .spiSdi(sdi), .spiSdo(sdo), .spiSdoOe(sdoOe),
        .adcData(adc), .pllEnable(pllEn), .dllEnable(dllEn), .adcCalDone(adcCal), .pllCalDone(pllCal),
        .synthOscillatorLowDrift(lowDrift), .synthOscillatorHighDrift(highDrift), .refPowerEn(refEn),
        .clockPowerEn(clkEn), .analogPowerEn(anaEn), .clockDistEn(distEn), .calRegsInit(calInit),
        .calStart(calSt), .pllCalStart(pllSt), .dllResetPulse(dllRst), .dataOut(dout), .dataOutValid(valid),
        .outputClockPinsP(pinP), .outputClockPinsN(pinN), .outClkFullRate(fullRate)
    );
    cmor_spi_host i_cmor_spi_host (.clk(clk), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (calSt === 1'b1) calSeen++;

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_cmor_spi_host.xfer(1'b0, a, d, lsbMode, q);
    endtask
    task automatic rdChk(input string what, input logic [8:0] a, input logic [7:0] exp);
        logic [7:0] q;
        i_cmor_spi_host.xfer(1'b1, a, 8'h00, lsbMode, q);
        check(what, {8'h00, q}, {8'h00, exp});
    endtask
    // Cycles between two events: output words, or clock pin edges; 0 if none within lim
    task automatic gap(input bit pin, input int lim, output int n);
        logic prv, hit;
        int   k;
        n = 0;
        k = 0;
        prv = pinP;
        repeat (lim) begin
            @(negedge clk);
            hit = pin ? (pinP !== prv) : (valid === 1'b1);
            prv = pinP;
            if (hit && k > 0) return_n: begin n = k; return; end
            if (hit || k > 0) k++;
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rdChk("mode", MODE_ADDR, 8'h24);
        rdChk("indep", INDEP_ADDR, 8'h0F);
        rdChk("rate", RATE_ADDR, 8'h00);
        rdChk("idLo", IDLO_ADDR, ID[7:0]);
        rdChk("idHi", IDHI_ADDR, ID[15:8]);
        wr(IDHI_ADDR, 8'h00);
        rdChk("idRo", IDHI_ADDR, ID[15:8]);
        rdChk("unmapped", 9'h0FF, 8'h00);
        check("fullRate", 16'({pinP, pinN, fullRate}), 16'h3);
    endtask
    task automatic t_standby_restart();
        @(posedge clk);
        #1 {adcCal, pllCal, lowDrift} = 3'h7;
        @(posedge clk);
        #1 {adcCal, pllCal} = 2'h0;
        rdChk("calStat", CALSTAT_ADDR, 8'h80);
        rdChk("pllStat", PLLSTAT_ADDR, 8'h24);
        wr(RATE_ADDR, 8'h12);
        wr(MODE_ADDR, 8'hFC);
        rdChk("mirror", MODE_ADDR, 8'h3C);
        check("standby", 16'({refEn, clkEn, anaEn, distEn}), 16'hD);
        wr(MODE_ADDR, 8'h00); // Restart asserted while leaving standby
        check("restart", 16'({refEn, clkEn, anaEn, distEn, calInit}), 16'h1D);
        rdChk("calClr", CALSTAT_ADDR, 8'h00);
        rdChk("rateKept", RATE_ADDR, 8'h12);
        {pllEn, dllEn, lowDrift, highDrift} = 4'hD;
        calSeen = 0;
        wr(MODE_ADDR, 8'h04);
        check("calRun", 16'(calSeen), 16'h1);
        check("active", 16'({refEn, clkEn, anaEn, distEn, calInit}), 16'h1E);
        rdChk("drift", PLLSTAT_ADDR, 8'h02);
    endtask
    task automatic t_shutdown();
        wr(MODE_ADDR, 8'h05);
        check("shutPwr", 16'({refEn, clkEn, anaEn, distEn}), 16'h0);
        rdChk("shutMode", MODE_ADDR, 8'hA5);
        rdChk("shutKeep", RATE_ADDR, 8'h12);
        wr(MODE_ADDR, 8'h00); // Restart asserted while leaving shutdown
        wr(MODE_ADDR, 8'h04);
        check("wake", 16'({refEn, clkEn, anaEn, distEn}), 16'hF);
    endtask
    task automatic t_bit_order();
        wr(MODE_ADDR, 8'h06);
        lsbMode = 1'b1;
        rdChk("lsbMode", MODE_ADDR, 8'h66);
        wr(RATE_ADDR, 8'h31);
        rdChk("lsbRate", RATE_ADDR, 8'h31);
        wr(MODE_ADDR, 8'h04);
        lsbMode = 1'b0;
        rdChk("msbBack", MODE_ADDR, 8'h24);
    endtask
    task automatic t_rates();
        int         n;
        logic [3:0] holds [6] = '{4'h0, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
        for (int c = 0; c < 10; c++) begin
            wr(RATE_ADDR, {c[3:0], 4'h0}); // Rate set for the output path
            gap(1'b0, 2000, n);
            gap(1'b0, 2000, n);
            check("dataGap", 16'(n), 16'(1 << c));
            check("dataWord", 16'(dout), 16'(adc));
        end
        wr(RATE_ADDR, 8'h35);
        gap(1'b1, 200, n);
        gap(1'b1, 200, n);
        check("follow", 16'(n), 16'h4);
        wr(INDEP_ADDR, 8'h8F);
        gap(1'b1, 200, n);
        gap(1'b1, 200, n);
        check("indep", 16'(n), 16'h10);
        for (int c = 1; c < 10; c++) begin
            wr(RATE_ADDR, {4'h0, c[3:0]});
            gap(1'b1, 1200, n);
            gap(1'b1, 1200, n);
            check("clkGap", 16'(n), 16'(1 << (c - 1)));
        end
        foreach (holds[i]) begin
            wr(RATE_ADDR, {4'h0, holds[i]});
            gap(1'b1, 64, n);
            check("hold", 16'({n != 0, pinP, pinN, fullRate}), 16'h2);
        end
        wr(RATE_ADDR, 8'h0F);
        gap(1'b1, 64, n);
        check("full", 16'({n != 0, fullRate}), 16'h1);
        for (int c = 13; c < 16; c++) begin
            wr(RATE_ADDR, {c[3:0], 4'h0});
            gap(1'b0, 2000, n);
            check("zeroData", 16'(dout), 16'h0);
        end
    endtask

    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Whole run needs about 35000 cycles; the margin absorbs slow filters
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        test_done();
    end
    initial begin
        {resetn, pllEn, dllEn, adcCal, pllCal, lowDrift, highDrift, lsbMode} = 8'h00;
        adc = 14'h1ABC;
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (6) @(posedge clk);
        t_reset();
        t_standby_restart();
        t_shutdown();
        t_bit_order();
        t_rates();
        test_done();
    end
endmodule // tb_cmor_regs

bind cmor_regs cmor_regs_chk i_cmor_regs_chk (
    .clk(clk), .resetn(resetn), .spiCsN(spiCsN), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe), .pllEnable(pllEnable),
    .dllEnable(dllEnable), .refPowerEn(refPowerEn), .clockPowerEn(clockPowerEn), .analogPowerEn(analogPowerEn),
    .clockDistEn(clockDistEn), .calRegsInit(calRegsInit), .calStart(calStart), .pllCalStart(pllCalStart),
    .dllResetPulse(dllResetPulse), .dataOutValid(dataOutValid), .outputClockPinsP(outputClockPinsP),
    .outputClockPinsN(outputClockPinsN), .outClkFullRate(outClkFullRate)
);

/* File: verilog/cmor_pkg.sv */
package cmor_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [8:0] MODE_ADDR    = 9'h000;
    localparam logic [8:0] INDEP_ADDR   = 9'h001;
    localparam logic [8:0] RATE_ADDR    = 9'h002;
    localparam logic [8:0] CALSTAT_ADDR = 9'h0C0;
    localparam logic [8:0] PLLSTAT_ADDR = 9'h0C1;
    localparam logic [8:0] IDLO_ADDR    = 9'h15C;
    localparam logic [8:0] IDHI_ADDR    = 9'h15D;

    localparam logic [7:0] MODE_RST  = 8'h24;
    localparam logic [7:0] INDEP_RST = 8'h0F;
    localparam logic [7:0] RATE_RST  = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int MODE_SHUTDOWN_BIT = 0;
    localparam int MODE_LSBFIRST_BIT = 1;
    localparam int MODE_SOFTRSTN_BIT = 2;
    localparam int MODE_STANDBY_BIT  = 3;
    localparam int INDEP_EN_BIT      = 7;
    localparam int CALSTAT_BIT       = 7;
    localparam int PLL_CAL_BIT       = 5;
    localparam int PLL_LOWDRIFT_BIT  = 2;
    localparam int PLL_HIGHDRIFT_BIT = 1;

    // ****************************************
    // Rate codes
    // ****************************************
    localparam logic [3:0] RATE_FULL     = 4'h0;
    localparam logic [3:0] RATE_MAXDIV   = 4'h9;
    localparam logic [3:0] DATA_ZERO_MIN = 4'hD;
    localparam logic [3:0] CLK_FULL      = 4'hF;

    // ****************************************
    // Serial frame
    // ****************************************
    localparam logic [4:0] HDR_LAST_BIT  = 5'h0F;
    localparam logic [4:0] DATA_FIRST    = 5'h10;
    localparam logic [4:0] FRAME_LAST    = 5'h17;
    localparam logic [4:0] FRAME_BITS    = 5'h18;
    localparam int         HDR_RW_BIT    = 15;
    localparam logic [2:0] SYNC_RST      = 3'h0;
    localparam logic [2:0] CS_SYNC_RST   = 3'h7;

    typedef enum logic [3:0] {
        PWR_ACTIVE   = 4'b0001,
        PWR_STANDBY  = 4'b0010,
        PWR_SOFTRST  = 4'b0100,
        PWR_SHUTDOWN = 4'b1000
    } cmor_pwr_t;

    // Tick when the low 'code' bits of the free counter are all ones
    function automatic logic ratePulse(input logic [8:0] cnt, input logic [3:0] code);
        logic [8:0] mask;
        mask = (9'h001 << code) - 9'h001;
        return (cnt & mask) == mask;
    endfunction

endpackage

/* File: verilog/cmor_reg_if.sv */
`timescale 1ns/1ns
interface cmor_reg_if;
    logic       wrStb;
    logic [8:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic       lsbFirst;

    modport spi (output wrStb, output addr, output wrData, input rdData, input lsbFirst);
    modport regs(input wrStb, input addr, input wrData, output rdData, output lsbFirst);
endinterface

/* File: verilog/cmor_regs.sv */
`timescale 1ns/1ns
module cmor_regs
    import cmor_pkg::*;
#(
    parameter logic [15:0] DEVICE_ID = 16'h5A3C // Arbitrary value
) (
    input  logic        clk,
    input  logic        resetn,
    input  logic        spiSclk,
    input  logic        spiCsN,
    input  logic        spiSdi,
    output logic        spiSdo,
    output logic        spiSdoOe,
    input  logic [13:0] adcData,
    input  logic        pllEnable,
    input  logic        dllEnable,
    input  logic        adcCalDone,
    input  logic        pllCalDone,
    input  logic        synthOscillatorLowDrift,
    input  logic        synthOscillatorHighDrift,
    output logic        refPowerEn,
    output logic        clockPowerEn,
    output logic        analogPowerEn,
    output logic        clockDistEn,
    output logic        calRegsInit,
    output logic        calStart,
    output logic        pllCalStart,
    output logic        dllResetPulse,
    output logic [13:0] dataOut,
    output logic        dataOutValid,
    output logic        outputClockPinsP,
    output logic        outputClockPinsN,
    output logic        outClkFullRate
);

    // ****************************************
    // Serial access
    // ****************************************
    cmor_reg_if regIf();

    cmor_spi_slave u_spi (
        .clk    (clk),
        .resetn (resetn),
        .sclkPin(spiSclk),
        .csPinN (spiCsN),
        .sdiPin (spiSdi),
        .sdo    (spiSdo),
        .sdoOe  (spiSdoOe),
        .regIf  (regIf)
    );

    // ****************************************
    // User registers
    // ****************************************
    logic [7:0] mode_r;
    logic [7:0] indep_r;
    logic [7:0] rate_r;
    logic [3:0] wrLow;

    assign wrLow = regIf.wrData[3:0];

    // User registers only see the bus reset, never the soft restart
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_r  <= MODE_RST;
            indep_r <= INDEP_RST;
            rate_r  <= RATE_RST;
        end else if (regIf.wrStb) begin
            case (regIf.addr)
                MODE_ADDR: begin
                    mode_r <= {wrLow[0], wrLow[1], wrLow[2], wrLow[3], wrLow};
                end
                INDEP_ADDR: begin
                    indep_r <= regIf.wrData;
                end
                RATE_ADDR: begin
                    rate_r <= regIf.wrData;
                end
                default: begin
                end
            endcase
        end
    end

    // Lower nibble alone steers the device
    logic shutdownReq;
    logic softRstN;
    logic standbyReq;

    assign shutdownReq    = mode_r[MODE_SHUTDOWN_BIT];
    assign softRstN       = mode_r[MODE_SOFTRSTN_BIT];
    assign standbyReq     = mode_r[MODE_STANDBY_BIT];
    assign regIf.lsbFirst = mode_r[MODE_LSBFIRST_BIT];

    // ****************************************
    // Power state
    // ****************************************
    cmor_pwr_t pwr_r;
    cmor_pwr_t pwr_nxt;

    // Shutdown outranks soft restart, which outranks standby
    always_comb begin
        if (shutdownReq)     pwr_nxt = PWR_SHUTDOWN;
        else if (!softRstN)  pwr_nxt = PWR_SOFTRST;
        else if (standbyReq) pwr_nxt = PWR_STANDBY;
        else                 pwr_nxt = PWR_ACTIVE;
    end

    always_ff @(posedge clk) begin
        if (!resetn) pwr_r <= PWR_ACTIVE;
        else         pwr_r <= pwr_nxt;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            refPowerEn    <= 1'b1;
            clockPowerEn  <= 1'b1;
            analogPowerEn <= 1'b1;
            clockDistEn   <= 1'b1;
            calRegsInit   <= 1'b0;
        end else begin
            case (pwr_r)
                PWR_SHUTDOWN: begin
                    refPowerEn    <= 1'b0;
                    clockPowerEn  <= 1'b0;
                    analogPowerEn <= 1'b0;
                    clockDistEn   <= 1'b0;
                    calRegsInit   <= !softRstN;
                end
                PWR_SOFTRST: begin
                    refPowerEn    <= 1'b1;
                    clockPowerEn  <= 1'b1;
                    analogPowerEn <= 1'b1;
                    clockDistEn   <= 1'b0;
                    calRegsInit   <= 1'b1;
                end
                PWR_STANDBY: begin
                    refPowerEn    <= 1'b1;
                    clockPowerEn  <= 1'b1;
                    analogPowerEn <= 1'b0;
                    clockDistEn   <= 1'b1;
                    calRegsInit   <= 1'b0;
                end
                default: begin
                    refPowerEn    <= 1'b1;
                    clockPowerEn  <= 1'b1;
                    analogPowerEn <= 1'b1;
                    clockDistEn   <= 1'b1;
                    calRegsInit   <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Calibration on restart release
    // ****************************************
    logic softRstNPrev_r;
    logic restartRelease;

    assign restartRelease = softRstN && !softRstNPrev_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            softRstNPrev_r <= 1'b1;
            calStart       <= 1'b0;
            pllCalStart    <= 1'b0;
            dllResetPulse  <= 1'b0;
        end else begin
            softRstNPrev_r <= softRstN;
            calStart       <= restartRelease;
            pllCalStart    <= restartRelease && pllEnable;
            dllResetPulse  <= restartRelease && dllEnable;
        end
    end

    // Done events win over the clear held by soft restart
    logic adcCalStat_r;
    logic pllCalStat_r;
    logic lowDrift_r;
    logic highDrift_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            adcCalStat_r <= 1'b0;
            pllCalStat_r <= 1'b0;
            lowDrift_r   <= 1'b0;
            highDrift_r  <= 1'b0;
        end else begin
            if (adcCalDone)                     adcCalStat_r <= 1'b1;
            else if (calRegsInit || calStart)   adcCalStat_r <= 1'b0;
            if (pllCalDone)                     pllCalStat_r <= 1'b1;
            else if (calRegsInit || pllCalStart) pllCalStat_r <= 1'b0;
            lowDrift_r  <= synthOscillatorLowDrift;
            highDrift_r <= synthOscillatorHighDrift;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        regIf.rdData = 8'h00;
        case (regIf.addr)
            MODE_ADDR:    regIf.rdData = mode_r;
            INDEP_ADDR:   regIf.rdData = indep_r;
            RATE_ADDR:    regIf.rdData = rate_r;
            CALSTAT_ADDR: regIf.rdData[CALSTAT_BIT] = adcCalStat_r;
            PLLSTAT_ADDR: begin
                regIf.rdData[PLL_CAL_BIT]       = pllCalStat_r;
                regIf.rdData[PLL_LOWDRIFT_BIT]  = lowDrift_r;
                regIf.rdData[PLL_HIGHDRIFT_BIT] = highDrift_r;
            end
            IDLO_ADDR:    regIf.rdData = DEVICE_ID[7:0];
            IDHI_ADDR:    regIf.rdData = DEVICE_ID[15:8];
            default:      regIf.rdData = 8'h00;
        endcase
    end

    // ****************************************
    // Output rate dividers
    // ****************************************
    logic [3:0] dataCode;
    logic [3:0] clkCode;
    logic [8:0] rateCnt_r;
    logic       running;
    logic       dataZero;
    logic       clkDivided;

    assign dataCode = rate_r[7:4];
    assign running  = (pwr_r == PWR_ACTIVE);

    // Without independence the clock follows the data divider
    always_comb begin
        if (indep_r[INDEP_EN_BIT])                         clkCode = rate_r[3:0];
        else if (dataCode == RATE_FULL)                    clkCode = CLK_FULL;
        else if (dataCode <= RATE_MAXDIV)                  clkCode = dataCode;
        else if (dataCode >= DATA_ZERO_MIN)                clkCode = CLK_FULL;
        else                                               clkCode = RATE_FULL;
    end

    // Test codes are undefined, so they are zeroed like the zero codes
    assign dataZero   = dataCode > RATE_MAXDIV;
    assign clkDivided = clkCode != RATE_FULL && clkCode <= RATE_MAXDIV;

    // Counter halts with the clocks so dividers restart in phase
    always_ff @(posedge clk) begin
        if (!resetn || !running) rateCnt_r <= 9'h000;
        else                     rateCnt_r <= rateCnt_r + 9'h001;
    end

    always_ff @(posedge clk) begin
        if (!resetn || !running) begin
            dataOut      <= 14'h0000;
            dataOutValid <= 1'b0;
        end else begin
            dataOutValid <= ratePulse(rateCnt_r, dataCode);
            if (ratePulse(rateCnt_r, dataCode)) begin
                dataOut <= dataZero ? 14'h0000 : adcData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || !running || !clkDivided) begin
            outputClockPinsP <= 1'b0;
            outputClockPinsN <= 1'b1;
        end else if (ratePulse(rateCnt_r, clkCode - 4'h1)) begin
            outputClockPinsP <= !outputClockPinsP;
            outputClockPinsN <= outputClockPinsP;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) outClkFullRate <= 1'b0;
        else         outClkFullRate <= running && clkCode == CLK_FULL;
    end

endmodule // cmor_regs

/* File: verilog/cmor_spi_slave.sv */
`timescale 1ns/1ns
module cmor_spi_slave
    import cmor_pkg::*;
(
    input  logic clk,
    input  logic resetn,
    input  logic sclkPin,
    input  logic csPinN,
    input  logic sdiPin,
    output logic sdo,
    output logic sdoOe,
    cmor_reg_if.spi regIf
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0]  sclkSync_r;
    logic [2:0]  csSync_r;
    logic [2:0]  sdiSync_r;
    logic        sclkLvl_r;
    logic        csLvlN_r;
    logic        sdiLvl_r;
    logic        sclkRise;
    logic        sclkFall;
    logic [4:0]  bitCnt_r;
    logic [15:0] hdr_r;
    logic [7:0]  dat_r;
    logic [7:0]  datNxt;
    logic [7:0]  tx_r;
    logic        loadTx_r;
    logic        wrStb_r;
    logic [7:0]  wrData_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sclkSync_r <= SYNC_RST;
            csSync_r   <= CS_SYNC_RST;
            sdiSync_r  <= SYNC_RST;
        end else begin
            sclkSync_r <= {sclkSync_r[1:0], sclkPin};
            csSync_r   <= {csSync_r[1:0], csPinN};
            sdiSync_r  <= {sdiSync_r[1:0], sdiPin};
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sclkLvl_r <= 1'b0;
            csLvlN_r  <= 1'b1;
            sdiLvl_r  <= 1'b0;
        end else begin
            if (sclkSync_r[1] == sclkSync_r[2]) sclkLvl_r <= sclkSync_r[2];
            if (csSync_r[1] == csSync_r[2])     csLvlN_r  <= csSync_r[2];
            if (sdiSync_r[1] == sdiSync_r[2])   sdiLvl_r  <= sdiSync_r[2];
        end
    end

    assign sclkRise = (sclkSync_r[1] == sclkSync_r[2]) && sclkSync_r[2] && !sclkLvl_r && !csLvlN_r;
    assign sclkFall = (sclkSync_r[1] == sclkSync_r[2]) && !sclkSync_r[2] && sclkLvl_r && !csLvlN_r;

    // ****************************************
    // Frame shifter
    // ****************************************
    assign datNxt = regIf.lsbFirst ? {sdiLvl_r, dat_r[7:1]} : {dat_r[6:0], sdiLvl_r};

    always_ff @(posedge clk) begin
        if (!resetn || csLvlN_r) begin
            bitCnt_r <= 5'h00;
        end else if (sclkRise && bitCnt_r != FRAME_BITS) begin
            bitCnt_r <= bitCnt_r + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hdr_r <= 16'h0000;
            dat_r <= 8'h00;
        end else if (sclkRise && bitCnt_r <= HDR_LAST_BIT) begin
            hdr_r <= regIf.lsbFirst ? {sdiLvl_r, hdr_r[15:1]} : {hdr_r[14:0], sdiLvl_r};
        end else if (sclkRise && bitCnt_r <= FRAME_LAST) begin
            dat_r <= datNxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrStb_r  <= 1'b0;
            wrData_r <= 8'h00;
        end else begin
            wrStb_r <= sclkRise && bitCnt_r == FRAME_LAST && !hdr_r[HDR_RW_BIT];
            if (sclkRise && bitCnt_r == FRAME_LAST) wrData_r <= datNxt;
        end
    end

    // Read data is captured one cycle after the header completes
    always_ff @(posedge clk) begin
        if (!resetn) begin
            loadTx_r <= 1'b0;
            tx_r     <= 8'h00;
        end else begin
            loadTx_r <= sclkRise && bitCnt_r == HDR_LAST_BIT;
            if (loadTx_r) tx_r <= regIf.rdData;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || csLvlN_r) begin
            sdo   <= 1'b0;
            sdoOe <= 1'b0;
        end else if (sclkFall && hdr_r[HDR_RW_BIT] && bitCnt_r >= DATA_FIRST && bitCnt_r <= FRAME_LAST) begin
            sdoOe <= 1'b1;
            sdo   <= regIf.lsbFirst ? tx_r[bitCnt_r[2:0]] : tx_r[3'h7 - bitCnt_r[2:0]];
        end
    end

    assign regIf.wrStb  = wrStb_r;
    assign regIf.wrData = wrData_r;
    assign regIf.addr   = hdr_r[8:0];

endmodule // cmor_spi_slave
